// >>> rtl/smt_map.svh
`ifndef SMT_MAP_SVH
`define SMT_MAP_SVH

// ----------------------------------------
// address byte layout
// ----------------------------------------
`define SMT_TYPE_MSB     7
`define SMT_TYPE_LSB     4
`define SMT_PAGE_MSB     3
`define SMT_PAGE_LSB     1
`define SMT_RW_BIT       0
// arbitrary device-type value, set per product
`define SMT_TYPE_CODE    4'h6
`define SMT_RW_READ      1'h1

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define SMT_ADDR_W       11
`define SMT_DATA_W       8
`define SMT_BIT_LAST     3'h7
`define SMT_ADDR_RST     11'h000
`define SMT_ADDR_TOP     11'h7FF

`endif

// >>> rtl/smt_pkg.sv
package smt_pkg;

   typedef enum logic [2:0]
   {
      SMT_IDLE  = 3'b000,
      SMT_DEV   = 3'b001,
      SMT_WORD  = 3'b010,
      SMT_WDATA = 3'b011,
      SMT_RDATA = 3'b100,
      SMT_ACKO  = 3'b101,
      SMT_ACKI  = 3'b110
   } smt_state_t;

   typedef struct packed
   {
      smt_state_t  st;
      smt_state_t  after;
      logic        scl_d;
      logic        sda_d;
      logic [2:0]  bitn;
      logic [7:0]  shreg;
      logic [10:0] addr;
      logic        is_read;
      logic        sda_oe;
      logic        mem_we;
      logic [10:0] mem_addr;
      logic [7:0]  mem_wdata;
      logic        rd_phase;
   } smt_regs_t;

endpackage : smt_pkg

// >>> rtl/smt_target.sv
`include "smt_map.svh"
// Functional notes
// - rising data while clock high is stop
// - stop abandons transfer, back to idle
// - falling data while clock high restarts
// - data stable while clock is high
// - receiver pulls low in ninth clock
// - high in acknowledge slot ends transfer
// - first byte is address, type must match
// - bits three to one select page
// - bit zero one means read
// - write second byte loads low address
// - read keeps low latch, takes page
// - address increments before acknowledge slot
// - top location wraps to zero
// - no limit on bytes per transfer
// - read sends byte, samples acknowledge
// - write takes byte, drives acknowledge
// - most significant bit first
// - target only, never drives clock
// - sample on rise, change on fall
// - protect input refuses data, holds address
// - commit after eighth bit, abort earlier
module smt_target
   import smt_pkg::*;
#(
   parameter logic [3:0] TYPE_CODE = `SMT_TYPE_CODE
)
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        clk_en_i,
   // two-wire bus pins and write protect
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        wp_i,
   // memory array port
   output logic             mem_we_o,
   output logic [10:0]      mem_addr_o,
   output logic [7:0]       mem_wdata_o,
   input  wire logic [7:0]  mem_rdata_i
);

   smt_regs_t r_reg;
   smt_regs_t r_next;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [10:0] smt_inc(input logic [10:0] a);
      // natural wrap of the 11-bit counter
      smt_inc = (a == `SMT_ADDR_TOP) ? `SMT_ADDR_RST : a + 11'h001;
   endfunction : smt_inc

   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   always_comb
   begin
      scl_rise = scl_i & ~r_reg.scl_d;
      scl_fall = ~scl_i & r_reg.scl_d;
      start_c  = scl_i & r_reg.scl_d & r_reg.sda_d & ~sda_i;
      stop_c   = scl_i & r_reg.scl_d & ~r_reg.sda_d & sda_i;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      r_next        = r_reg;
      r_next.scl_d  = scl_i;
      r_next.sda_d  = sda_i;
      r_next.mem_we = 1'b0;
      // array port follows the latch one cycle late, write strobe included
      r_next.mem_addr = r_reg.addr;
      if (start_c)
      begin
         // abandon anything and wait for the address byte
         r_next.st       = SMT_DEV;
         r_next.bitn     = 3'h0;
         r_next.sda_oe   = 1'b0;
         r_next.rd_phase = 1'b0;
      end
      else if (stop_c)
      begin
         r_next.st       = SMT_IDLE;
         r_next.sda_oe   = 1'b0;
         r_next.rd_phase = 1'b0;
      end
      else
      begin
         case (r_reg.st)
            SMT_IDLE:
            begin
               r_next.sda_oe = 1'b0;
            end
            SMT_DEV, SMT_WORD, SMT_WDATA:
            begin
               if (scl_rise)
               begin
                  r_next.shreg = {r_reg.shreg[6:0], sda_i};
                  r_next.bitn  = r_reg.bitn + 3'h1;
                  if (r_reg.bitn == `SMT_BIT_LAST)
                  begin
                     r_next.st = SMT_ACKO;
                     if (r_reg.st == SMT_DEV)
                     begin
                        if (r_reg.shreg[6:3] != TYPE_CODE)
                        begin
                           r_next.st = SMT_IDLE;
                        end
                        else
                        begin
                           r_next.addr[10:8] = r_reg.shreg[2:0];
                           r_next.is_read    = sda_i;
                           r_next.after      = sda_i ? SMT_RDATA : SMT_WORD;
                        end
                     end
                     else if (r_reg.st == SMT_WORD)
                     begin
                        r_next.addr[7:0] = {r_reg.shreg[6:0], sda_i};
                        r_next.after     = SMT_WDATA;
                     end
                     else if (wp_i)
                     begin
                        // protected: no ack, counter held
                        r_next.after = SMT_IDLE;
                     end
                     else
                     begin
                        r_next.mem_we    = 1'b1;
                        r_next.mem_addr  = r_reg.addr;
                        r_next.mem_wdata = {r_reg.shreg[6:0], sda_i};
                        r_next.addr      = smt_inc(r_reg.addr);
                        r_next.after     = SMT_WDATA;
                     end
                  end
               end
            end
            SMT_ACKO:
            begin
               // drive ack low from the fall after bit eight
               if (scl_fall)
               begin
                  if (r_reg.rd_phase)
                  begin
                     r_next.rd_phase = 1'b0;
                     r_next.sda_oe   = 1'b0;
                     r_next.st       = r_reg.after;
                     r_next.bitn     = 3'h0;
                     if (r_reg.after == SMT_RDATA)
                     begin
                        r_next.shreg  = mem_rdata_i;
                        r_next.sda_oe = ~mem_rdata_i[7];
                        r_next.bitn   = 3'h1;
                     end
                  end
                  else
                  begin
                     r_next.rd_phase = 1'b1;
                     r_next.sda_oe   = (r_reg.after != SMT_IDLE);
                  end
               end
            end
            SMT_RDATA:
            begin
               if (scl_fall)
               begin
                  if (r_reg.bitn == 3'h0)
                  begin
                     // byte out, release for controller ack
                     r_next.sda_oe = 1'b0;
                     r_next.addr   = smt_inc(r_reg.addr);
                     r_next.st     = SMT_ACKI;
                  end
                  else
                  begin
                     r_next.sda_oe = ~r_reg.shreg[3'h7 - r_reg.bitn];
                     r_next.bitn   = r_reg.bitn + 3'h1;
                  end
               end
            end
            SMT_ACKI:
            begin
               if (scl_rise)
               begin
                  r_next.rd_phase = ~sda_i;
               end
               if (scl_fall)
               begin
                  if (r_reg.rd_phase)
                  begin
                     r_next.shreg  = mem_rdata_i;
                     r_next.sda_oe = ~mem_rdata_i[7];
                     r_next.bitn   = 3'h1;
                     r_next.st     = SMT_RDATA;
                  end
                  else
                  begin
                     r_next.st = SMT_IDLE;
                  end
                  r_next.rd_phase = 1'b0;
               end
            end
            default:
            begin
               r_next.st = SMT_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         r_reg           <= '0;
         r_reg.st        <= SMT_IDLE;
         r_reg.after     <= SMT_IDLE;
         r_reg.scl_d     <= 1'b1;
         r_reg.sda_d     <= 1'b1;
         r_reg.addr      <= `SMT_ADDR_RST;
      end
      else if (clk_en_i)
      begin
         r_reg <= r_next;
      end
   end

   // open drain: only ever pulls low, clock never driven
   assign sda_o       = 1'b0;
   assign sda_oe_o    = r_reg.sda_oe;
   assign mem_we_o    = r_reg.mem_we;
   assign mem_addr_o  = r_reg.mem_addr;
   assign mem_wdata_o = r_reg.mem_wdata;

endmodule : smt_target

// >>> test/smt_target_monitor.sv
module smt_target_monitor
(
   // watched ports
   input wire logic        sys_clk_i,
   input wire logic        resetn_i,
   input wire logic        clk_en_i,
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic        wp_i,
   input wire logic        mem_we_o,
   input wire logic [10:0] mem_addr_o,
   input wire logic [7:0]  mem_wdata_o,
   input wire logic [7:0]  mem_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] nxt_reg;
   // 11-bit sum, so the top location rolls to zero here too
   always_ff @(posedge sys_clk_i)
   begin
      if (mem_we_o)
      begin
         nxt_reg <= mem_addr_o + 11'h1;
      end
   end
   // -----
   // checks
   // -----
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   drv_low_a: assert property (sda_o == 1'b0) else $error("data value not low");
   oe_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
   oe_hold_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8]) else $error("pull dropped early");
   we_pulse_a: assert property (mem_we_o |=> !mem_we_o) else $error("write strobe too long");
   we_prot_a: assert property (mem_we_o |-> !wp_i) else $error("write while protected");
   we_high_a: assert property (mem_we_o |-> scl_i) else $error("write outside clock high");
   ack_we_a: assert property (mem_we_o |-> ##[1:16] sda_oe_o) else $error("no ack after write");
   addr_inc_a: assert property (mem_we_o |-> ##[2:14] mem_addr_o == nxt_reg) else $error("no increment");
endmodule : smt_target_monitor

bind smt_target smt_target_monitor mon_u (.sys_clk_i, .resetn_i, .clk_en_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
   .wp_i, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i);

// >>> test/smt_ctl.sv
module smt_ctl
(
   // clock, bus and read result
   input  wire logic       sys_clk_i,
   input  wire logic       sda_i,
   output logic            scl_o = 1'b1,
   output logic            pull_o = 1'b0,
   output logic            rd_v_o = 1'b0,
   output logic [7:0]      rd_d_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----
   // bus phases, moved on the falling system edge
   // -----
   task automatic ph(input logic c, input logic p, input int n);
      scl_o = c;
      pull_o = p;
      repeat (n) @(negedge sys_clk_i);
   endtask : ph
   task automatic start();
      ph(scl_o, 1'b0, 4);
      ph(1'b1, 1'b0, 8);
      ph(1'b1, 1'b1, 8);
      ph(1'b0, 1'b1, 2);
   endtask : start
   task automatic stop();
      ph(1'b0, 1'b1, 8);
      ph(1'b1, 1'b1, 8);
      ph(1'b1, 1'b0, 8);
   endtask : stop
   // every data bit pulse comes from here; data set only while clock low
   task automatic tbit(input logic b, output logic r);
      ph(1'b0, ~b, 8);
      ph(1'b1, ~b, 8);
      r = sda_i;
      ph(1'b0, ~b, 2);
   endtask : tbit
   task automatic xbyte(input logic [7:0] d, input logic a, input logic rd, output logic k);
      logic [7:0] r;
      for (int i = 7; i >= 0; i--) tbit(d[i], r[i]);
      rd_d_o = r;
      rd_v_o = rd;
      tbit(a, k);
      rd_v_o = 1'b0;
   endtask : xbyte
endmodule : smt_ctl

// >>> test/smt_target_tb.sv
module smt_target_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        wp = 1'b0;
   logic        scl, pull, rd_v, sda_oe, mem_we, k;
   logic [7:0]  rd_d, mem_wdata, d;
   logic [10:0] mem_addr;
   logic [7:0]  mem [2048];
   logic [7:0]  ref_m [2048];
   logic [18:0] wq [$];
   logic [7:0]  rq [$];
   int          failures = 0;
   int          n_checks = 0;
   int          cyc = 0;
   wire         sda = ~(pull | sda_oe);
   always #4 sys_clk = ~sys_clk;
   smt_target dut_u (.sys_clk_i(sys_clk), .resetn_i(resetn), .clk_en_i(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_o(sda_oe), .wp_i(wp), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
      .mem_rdata_i(mem[mem_addr]));
   smt_ctl ctl_u (.sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .pull_o(pull), .rd_v_o(rd_v), .rd_d_o(rd_d));
   // -----
   // checking
   // -----
   task automatic chk(input string s, input logic [18:0] e, input logic [18:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic finish_test();
      if (failures == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic aw(input logic [3:0] t, input logic [2:0] pg, input logic rw, input logic ex);
      ctl_u.start();
      ctl_u.xbyte({t, pg, rw}, 1'b1, 1'b0, k);
      chk("address ack", ex, k);
   endtask : aw
   task automatic wb(input logic [7:0] v, input logic ex);
      ctl_u.xbyte(v, 1'b1, 1'b0, k);
      chk("data ack", ex, k);
   endtask : wb
   task automatic rd(input logic [10:0] at, input logic nk);
      rq.push_back(ref_m[at]);
      ctl_u.xbyte(8'hFF, nk, 1'b1, k);
   endtask : rd
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         failures++;
         finish_test();
      end
      if (mem_we === 1'b1)
      begin
         mem[mem_addr] <= mem_wdata;
         chk("array write", wq.size() > 0 ? wq.pop_front() : {19{1'bx}}, {mem_addr, mem_wdata});
      end
   end
   always @(posedge rd_v) chk("read data", rq.pop_front(), rd_d);
   initial
   begin
      void'($urandom(52095));
      for (int i = 0; i < 2048; i++)
      begin
         mem[i] = 8'($urandom);
         ref_m[i] = mem[i];
      end
      repeat (16) @(negedge sys_clk);
      resetn = 1'b1;
      aw(4'h6, 3'h7, 1'b0, 1'b0);
      wb(8'hFE, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         d = 8'($urandom);
         wq.push_back({11'h7FE + 11'(i), d});
         ref_m[11'h7FE + 11'(i)] = d;
         wb(d, 1'b0);
      end
      ctl_u.stop();
      aw(4'h6, 3'h3, 1'b1, 1'b0);
      rd(11'h301, 1'b0);
      rd(11'h302, 1'b1);
      ctl_u.stop();
      aw(4'h6, 3'h2, 1'b0, 1'b0);
      wb(8'h10, 1'b0);
      for (int i = 0; i < 4; i++) ctl_u.tbit(1'b0, k);
      ctl_u.stop();
      aw(4'h6, 3'h2, 1'b0, 1'b0);
      wb(8'h20, 1'b0);
      aw(4'h6, 3'h5, 1'b1, 1'b0);
      rd(11'h520, 1'b1);
      ctl_u.stop();
      aw(4'h5, 3'h0, 1'b0, 1'b1);
      ctl_u.stop();
      wp = 1'b1;
      aw(4'h6, 3'h1, 1'b0, 1'b0);
      wb(8'h40, 1'b0);
      wb(8'h5A, 1'b1);
      ctl_u.stop();
      wp = 1'b0;
      aw(4'h6, 3'h1, 1'b1, 1'b0);
      rd(11'h140, 1'b1);
      ctl_u.stop();
      repeat (50) @(negedge sys_clk);
      chk("queues empty", 19'h0, 19'(wq.size() + rq.size()));
      finish_test();
   end
endmodule : smt_target_tb
